/* File: gsa_gps_rx.sv */
// Receiver pulse source; also serves as the chained pulse line
module gsa_gps_rx (
   input wire logic ref_clk,
   input wire logic en,
   input wire logic [7:0] period,
   output logic pps
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_r = 8'h00;

   // Four-cycle pulse, first one right away; idle line rests low
   always @(posedge ref_clk) begin
      if (!en || cnt_r >= period - 8'h01) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
      pps <= en && (cnt_r < 8'h04);
   end
endmodule : gsa_gps_rx

/* File: gsa_pkg.sv */
package gsa_pkg;

   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned ONE_SEC_NS = 1000000000;
   localparam int unsigned SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;
   // Pulse spacing tolerance, either side of one second
   localparam int unsigned PPS_TOL_NS = 1000;
   localparam int unsigned TOL_CYCLES = PPS_TOL_NS / CLK_PERIOD_NS;
   localparam int unsigned SECS_PER_MIN = 60;
   // Length of a master's recovery window in seconds
   localparam int unsigned RECOV_SECS = 5;

   // Recovery interval in minutes
   localparam logic [10:0] INTERVAL_MIN = 11'h005;
   localparam logic [10:0] INTERVAL_MAX = 11'h5a0;
   localparam logic [10:0] INTERVAL_RST = 11'h00f;

   // Dwell times in milliseconds
   localparam logic [15:0] ADAPT_DWELL_MS = 16'h003c;
   localparam logic [15:0] DWELL_RST_MS = 16'h0014;

   // Pulse runs: one good interval is proper, two means three pulses
   localparam logic [1:0] RUN_PROPER = 2'h1;
   localparam logic [1:0] RUN_THREE = 2'h2;

   // Relay source selections
   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_RESERVED = 4'h6;
   localparam logic [3:0] SEL_LAST_IN = 4'ha;
   localparam logic [3:0] SEL_ANY = 4'hb;

   // Alarm vector bit positions (input n sits at bit n-1)
   localparam int unsigned ALM_GPS = 4;
   localparam int unsigned ALM_RSV = 5;

   typedef enum logic [1:0] {
      CTRL_OFF = 2'b00,
      CTRL_ON = 2'b01,
      CTRL_AUTO = 2'b10
   } gsa_ctrl_e;

   typedef enum logic [1:0] {
      SRC_GPS = 2'b00,
      SRC_INTERNAL = 2'b01,
      SRC_CHAIN = 2'b10,
      SRC_RECOVERY = 2'b11
   } gsa_src_e;

   typedef struct packed {
      logic auto_en;
      logic [10:0] interval_min;
      logic [2:0][3:0] relay_sel;
      logic [2:0][1:0] relay_ctrl;
      logic adaptive_dwell;
      logic [15:0] dwell_ms;
   } gsa_cfg_s;

   typedef struct packed {
      logic [3:0] contact_closed;
      logic left_supply_overtemp;
      logic right_supply_overtemp;
      logic left_supply_fail;
      logic right_supply_fail;
   } gsa_alarm_s;

   localparam gsa_cfg_s CFG_RST = '{
      auto_en: 1'b1,
      interval_min: INTERVAL_RST,
      relay_sel: {3{SEL_NONE}},
      relay_ctrl: {3{CTRL_AUTO}},
      adaptive_dwell: 1'b0,
      dwell_ms: DWELL_RST_MS
   };

endpackage : gsa_pkg

/* File: gsa_pps_check.sv */
module gsa_pps_check #(
   parameter int unsigned PERIOD = gsa_pkg::SEC_CYCLES,
   parameter int unsigned TOL = gsa_pkg::TOL_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic pps_in,
   output logic pps_edge_r,
   output logic [1:0] good_run_r
);

   localparam logic [31:0] WIN_LO = 32'(PERIOD - TOL);
   localparam logic [31:0] WIN_HI = 32'(PERIOD + TOL);

   logic pps_d_r;
   logic started_r;
   logic [31:0] cnt_r;
   logic rise;

   assign rise = pps_in & ~pps_d_r;

   // Edge detect of the pulse input
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pps_d_r <= 1'b0;
         pps_edge_r <= 1'b0;
      end else begin
         pps_d_r <= pps_in;
         pps_edge_r <= rise;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         started_r <= 1'b0;
         cnt_r <= 32'h0000_0000;
         good_run_r <= 2'h0;
      end else if (rise) begin
         started_r <= 1'b1;
         // Count from one so the count equals the spacing at the next rise
         cnt_r <= 32'h0000_0001;
         if (started_r && cnt_r >= WIN_LO && cnt_r <= WIN_HI) begin
            if (good_run_r != 2'h3) begin
               good_run_r <= good_run_r + 2'h1;
            end
         end else begin
            good_run_r <= 2'h0;
         end
      end else if (started_r) begin
         // A missing pulse ends the run; wait for a fresh first pulse
         if (cnt_r > WIN_HI) begin
            started_r <= 1'b0;
            good_run_r <= 2'h0;
         end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   late_pulse_a: assert property (
      started_r && !rise && cnt_r > WIN_HI |=> good_run_r == 2'h0)
      else $error("late pulse did not clear the run");
   early_pulse_a: assert property (
      rise && started_r && cnt_r < WIN_LO |=> good_run_r == 2'h0)
      else $error("early pulse did not clear the run");

endmodule : gsa_pps_check

/* File: gsa_relay_sel.sv */
module gsa_relay_sel (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [9:0] alarms,
   input wire logic [3:0] sel,
   input wire logic [1:0] ctrl,
   output logic relay_on_r
);

   logic auto_on;
   logic [3:0] idx;

   assign idx = sel - 4'h1;

   always_comb begin
      auto_on = 1'b0;
      if (sel == gsa_pkg::SEL_ANY) begin
         auto_on = |alarms;
      end else if (sel != gsa_pkg::SEL_NONE && sel != gsa_pkg::SEL_RESERVED
                   && sel <= gsa_pkg::SEL_LAST_IN) begin
         auto_on = alarms[idx];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         relay_on_r <= 1'b0;
      end else begin
         unique case (ctrl)
            gsa_pkg::CTRL_OFF: relay_on_r <= 1'b0;
            gsa_pkg::CTRL_ON: relay_on_r <= 1'b1;
            gsa_pkg::CTRL_AUTO: relay_on_r <= auto_on;
            default: relay_on_r <= 1'b0; // Code 3 is illegal
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   forced_off_a: assert property (
      ctrl == gsa_pkg::CTRL_OFF |=> !relay_on_r)
      else $error("relay on while forced off");
   reserved_sel_a: assert property (
      ctrl == gsa_pkg::CTRL_AUTO && sel == gsa_pkg::SEL_RESERVED
      |=> !relay_on_r)
      else $error("reserved selection energised relay");
   none_sel_a: assert property (
      ctrl == gsa_pkg::CTRL_AUTO && sel == gsa_pkg::SEL_NONE |=> !relay_on_r)
      else $error("selection none energised relay");

endmodule : gsa_relay_sel

/* File: gsa_top.sv */
// Operation
// - Pulse proper only when one second apart
// - Chain cable present means slave, else master
// - Bad master pulses: internal sync, also out
// - Bad slave pulses: follow and forward chain
// - Slave reverts after three good pulses
// - Master checks only in quiet recovery
// - Manual recovery runs whatever auto setting
// - Auto recovery enable, enabled after reset
// - Auto interval 5 to 1440 minutes, 15
// - Slave ignores manual and auto recovery
// - Four contact inputs active when closed
// - Inputs 7-10 supply temperature and failure
// - Input 5 shows proper receiver pulses
// - Input 6 reserved, never fires output
// - Three relays, common to open/closed
// - Auto selection: input, none or any
// - Selections reset to none
// - Control off, on, auto; resets auto
// - Inputs, outputs and settings readable
// - Adaptive dwell fixes dwell at 60 ms
module gsa_top #(
   parameter int unsigned SEC_CYCLES = gsa_pkg::SEC_CYCLES,
   parameter int unsigned TOL_CYCLES = gsa_pkg::TOL_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic gps_pps,
   input wire logic chain_cable_present,
   input wire logic chain_gps_pps,
   input wire logic chain_sync,
   input wire gsa_pkg::gsa_alarm_s alarm_pins,
   input wire logic manual_recovery_req,
   input wire logic cfg_load,
   input wire gsa_pkg::gsa_cfg_s cfg_in,
   output gsa_pkg::gsa_cfg_s cfg_r,
   output logic sync_out_r,
   output logic gps_pps_fwd_r,
   output gsa_pkg::gsa_src_e src_r,
   output logic is_slave_r,
   output logic pps_proper_r,
   output logic [9:0] alarm_in_state_r,
   output logic [2:0] relay_on,
   output logic [15:0] dwell_ms_eff_r
);

   logic pps_sel;
   logic pps_edge;
   logic [1:0] good_run;
   logic [31:0] sec_cnt_r;
   logic sec_tick_r;
   logic [5:0] min_sec_r;
   logic min_tick_r;
   logic [10:0] auto_min_r;
   logic [2:0] rec_sec_r;
   logic rec_done;
   logic auto_fire;
   logic start_rec;
   logic proper;
   logic three_ok;
   logic [10:0] interval_clamped;
   gsa_pkg::gsa_src_e src_nxt;

   // Slave watches receiver lines that arrive over the chain
   assign pps_sel = is_slave_r ? chain_gps_pps : gps_pps;
   assign proper = good_run >= gsa_pkg::RUN_PROPER;
   assign three_ok = good_run >= gsa_pkg::RUN_THREE;

   gsa_pps_check #(
      .PERIOD(SEC_CYCLES),
      .TOL(TOL_CYCLES)
   ) u_check (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pps_in(pps_sel),
      .pps_edge_r(pps_edge),
      .good_run_r(good_run)
   );

   // out of range intervals clamp to the limits
   always_comb begin
      interval_clamped = cfg_in.interval_min;
      if (cfg_in.interval_min < gsa_pkg::INTERVAL_MIN) begin
         interval_clamped = gsa_pkg::INTERVAL_MIN;
      end else if (cfg_in.interval_min > gsa_pkg::INTERVAL_MAX) begin
         interval_clamped = gsa_pkg::INTERVAL_MAX;
      end
   end

   // settings read back from this register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= gsa_pkg::CFG_RST;
      end else if (cfg_load) begin
         cfg_r <= cfg_in;
         cfg_r.interval_min <= interval_clamped;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         is_slave_r <= 1'b0;
      end else begin
         is_slave_r <= chain_cable_present;
      end
   end

   // Second tick doubles as the internal sync source
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_cnt_r <= 32'h0000_0000;
         sec_tick_r <= 1'b0;
      end else if (sec_cnt_r == 32'(SEC_CYCLES - 1)) begin
         sec_cnt_r <= 32'h0000_0000;
         sec_tick_r <= 1'b1;
      end else begin
         sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
         sec_tick_r <= 1'b0;
      end
   end

   // Minute tick from second ticks
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         min_sec_r <= 6'h00;
         min_tick_r <= 1'b0;
      end else if (is_slave_r || !cfg_r.auto_en || rec_done || start_rec) begin
         // Restart with the interval timer, else a start comes a minute early
         min_sec_r <= 6'h00;
         min_tick_r <= 1'b0;
      end else begin
         min_tick_r <= 1'b0;
         if (sec_tick_r) begin
            if (min_sec_r == 6'(gsa_pkg::SECS_PER_MIN - 1)) begin
               min_sec_r <= 6'h00;
               min_tick_r <= 1'b1;
            end else begin
               min_sec_r <= min_sec_r + 6'h01;
            end
         end
      end
   end

   // recovery starts only for a master
   // manual start independent of auto enable
   assign auto_fire = min_tick_r && cfg_r.auto_en
                      && auto_min_r == cfg_r.interval_min - 11'h001;
   assign start_rec = !is_slave_r && src_r != gsa_pkg::SRC_RECOVERY
                      && (manual_recovery_req || auto_fire);
   assign rec_done = src_r == gsa_pkg::SRC_RECOVERY && sec_tick_r
                     && rec_sec_r == 3'(gsa_pkg::RECOV_SECS - 1);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         auto_min_r <= 11'h000;
      end else if (is_slave_r || !cfg_r.auto_en || rec_done || start_rec) begin
         auto_min_r <= 11'h000;
      end else if (min_tick_r && src_r != gsa_pkg::SRC_RECOVERY) begin
         auto_min_r <= auto_min_r + 11'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rec_sec_r <= 3'h0;
      end else if (src_r != gsa_pkg::SRC_RECOVERY) begin
         rec_sec_r <= 3'h0;
      end else if (sec_tick_r) begin
         rec_sec_r <= rec_sec_r + 3'h1;
      end
   end

   // Source selection; master returns to receiver only via recovery
   always_comb begin
      src_nxt = src_r;
      unique case (src_r)
         gsa_pkg::SRC_GPS: begin
            if (is_slave_r) begin
               if (!proper) src_nxt = gsa_pkg::SRC_CHAIN;
            end else if (start_rec) begin
               // a requested recovery is never lost
               src_nxt = gsa_pkg::SRC_RECOVERY;
            end else if (!proper) begin
               // master falls back to internal clock
               src_nxt = gsa_pkg::SRC_INTERNAL;
            end
         end
         gsa_pkg::SRC_INTERNAL: begin
            if (is_slave_r) begin
               src_nxt = three_ok ? gsa_pkg::SRC_GPS : gsa_pkg::SRC_CHAIN;
            end else if (start_rec) begin
               src_nxt = gsa_pkg::SRC_RECOVERY;
            end
         end
         gsa_pkg::SRC_CHAIN: begin
            if (!is_slave_r) begin
               src_nxt = start_rec ? gsa_pkg::SRC_RECOVERY
                                   : gsa_pkg::SRC_INTERNAL;
            end else if (three_ok) begin
               src_nxt = gsa_pkg::SRC_GPS;
            end
         end
         gsa_pkg::SRC_RECOVERY: begin
            if (is_slave_r) begin
               src_nxt = gsa_pkg::SRC_CHAIN;
            end else if (rec_done) begin
               // validity judged at end of window
               src_nxt = proper ? gsa_pkg::SRC_GPS : gsa_pkg::SRC_INTERNAL;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         src_r <= gsa_pkg::SRC_INTERNAL;
      end else begin
         src_r <= src_nxt;
      end
   end

   // Sync output per source; silent during recovery
   // internal sync driven out
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_out_r <= 1'b0;
         gps_pps_fwd_r <= 1'b0;
      end else begin
         gps_pps_fwd_r <= pps_sel; // Next slave monitors these lines
         unique case (src_r)
            gsa_pkg::SRC_GPS: sync_out_r <= pps_edge;
            gsa_pkg::SRC_INTERNAL: sync_out_r <= sec_tick_r;
            gsa_pkg::SRC_CHAIN: sync_out_r <= chain_sync;
            gsa_pkg::SRC_RECOVERY: sync_out_r <= 1'b0;
         endcase
      end
   end

   // supply alarms on inputs 7 to 10
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alarm_in_state_r <= 10'h000;
         pps_proper_r <= 1'b0;
      end else begin
         pps_proper_r <= proper;
         alarm_in_state_r <= {alarm_pins.right_supply_fail,
                              alarm_pins.left_supply_fail,
                              alarm_pins.right_supply_overtemp,
                              alarm_pins.left_supply_overtemp,
                              1'b0, proper,
                              alarm_pins.contact_closed};
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_relay
      gsa_relay_sel u_relay (
         .ref_clk(ref_clk),
         .reset_n(reset_n),
         .alarms(alarm_in_state_r),
         .sel(cfg_r.relay_sel[i]),
         .ctrl(cfg_r.relay_ctrl[i]),
         .relay_on_r(relay_on[i])
      );
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dwell_ms_eff_r <= gsa_pkg::DWELL_RST_MS;
      end else begin
         dwell_ms_eff_r <= cfg_r.adaptive_dwell ? gsa_pkg::ADAPT_DWELL_MS
                                                : cfg_r.dwell_ms;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence manual_req_s;
      !is_slave_r && src_r != gsa_pkg::SRC_RECOVERY && manual_recovery_req;
   endsequence
   sequence enter_rec_s;
      src_r == gsa_pkg::SRC_RECOVERY && rec_sec_r == 3'h0;
   endsequence

   manual_start_a: assert property (
      manual_req_s |=> enter_rec_s)
      else $error("manual request did not start recovery");
   slave_no_rec_a: assert property (
      is_slave_r |=> src_r != gsa_pkg::SRC_RECOVERY)
      else $error("slave entered recovery");
   master_fallback_a: assert property (
      !is_slave_r && src_r == gsa_pkg::SRC_GPS && !proper
      |=> src_r == ($past(start_rec) ? gsa_pkg::SRC_RECOVERY
                                     : gsa_pkg::SRC_INTERNAL))
      else $error("master did not fall back to internal");
   internal_sync_a: assert property (
      src_r == gsa_pkg::SRC_INTERNAL && sec_tick_r |=> sync_out_r)
      else $error("internal sync not driven out");
   chain_follow_a: assert property (
      src_r == gsa_pkg::SRC_CHAIN |=> sync_out_r == $past(chain_sync))
      else $error("chain sync not forwarded");
   slave_revert_a: assert property (
      is_slave_r && src_r == gsa_pkg::SRC_CHAIN && three_ok
      |=> src_r == gsa_pkg::SRC_GPS)
      else $error("slave did not revert after three pulses");
   recovery_quiet_a: assert property (
      src_r == gsa_pkg::SRC_RECOVERY |=> !sync_out_r)
      else $error("sync output during recovery");
   adapt_dwell_a: assert property (
      cfg_r.adaptive_dwell ##1 cfg_r.adaptive_dwell
      |-> dwell_ms_eff_r == gsa_pkg::ADAPT_DWELL_MS)
      else $error("adaptive dwell not fixed");
   gps_alarm_a: assert property (
      1'b1 |=> alarm_in_state_r[gsa_pkg::ALM_GPS] == $past(proper)
               && !alarm_in_state_r[gsa_pkg::ALM_RSV])
      else $error("alarm input 5 or 6 wrong");

endmodule : gsa_top

/* File: tb_gsa_top.sv */
module tb_gsa_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 100;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic gps_en = 1'b0;
   logic chn_en = 1'b0;
   logic [7:0] gps_per = 8'h64;
   logic gps_pps;
   logic chain_gps_pps;
   logic chain_cable_present = 1'b0;
   logic chain_sync = 1'b0;
   logic manual_recovery_req = 1'b0;
   logic cfg_load = 1'b0;
   gsa_pkg::gsa_alarm_s alarm_pins = '0;
   gsa_pkg::gsa_cfg_s cfg_in = gsa_pkg::CFG_RST;
   gsa_pkg::gsa_cfg_s c;
   gsa_pkg::gsa_cfg_s cfg_r;
   gsa_pkg::gsa_src_e src_r;
   logic sync_out_r;
   logic pps_fwd;
   logic rec_d = 1'b0;
   logic slave_d = 1'b0;
   logic gps_d = 1'b0;
   logic chn_d = 1'b0;
   logic is_slave_r;
   logic pps_proper_r;
   logic [9:0] alarm_in_state_r;
   logic [9:0] a;
   logic [2:0] relay_on;
   logic [3:0] s;
   logic [15:0] dwell_ms_eff_r;
   int err_total = 0;
   int n_tests = 0;
   int n;

   // Free-running system clock
   always #4 ref_clk = ~ref_clk;

   // Receiver and chained pulse lines
   gsa_gps_rx u_gps (.ref_clk(ref_clk), .en(gps_en), .period(gps_per),
      .pps(gps_pps));
   gsa_gps_rx u_chn (.ref_clk(ref_clk), .en(chn_en), .period(8'h64),
      .pps(chain_gps_pps));

   // Short second keeps the run small; tolerance two cycles
   gsa_top #(.SEC_CYCLES(SEC), .TOL_CYCLES(2)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .gps_pps(gps_pps),
      .chain_cable_present(chain_cable_present),
      .chain_gps_pps(chain_gps_pps), .chain_sync(chain_sync),
      .alarm_pins(alarm_pins), .manual_recovery_req(manual_recovery_req),
      .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_r(cfg_r),
      .sync_out_r(sync_out_r), .gps_pps_fwd_r(pps_fwd), .src_r(src_r),
      .is_slave_r(is_slave_r), .pps_proper_r(pps_proper_r),
      .alarm_in_state_r(alarm_in_state_r), .relay_on(relay_on),
      .dwell_ms_eff_r(dwell_ms_eff_r));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // Load strobe, then let readback, dwell and relays settle
   task automatic load(input gsa_pkg::gsa_cfg_s v);
      @(posedge ref_clk);
      cfg_in <= v;
      cfg_load <= 1'b1;
      @(posedge ref_clk);
      cfg_load <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : load

   task automatic wait_src(input gsa_pkg::gsa_src_e w, input int lim);
      n = 0;
      while (src_r !== w && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
   endtask : wait_src

   // Adds sync pulses seen over a span to n
   task automatic count_sync(input int cyc);
      repeat (cyc) begin
         @(posedge ref_clk);
         #1;
         if (sync_out_r === 1'b1) n++;
      end
   endtask : count_sync

   task automatic pulse_manual;
      @(posedge ref_clk);
      manual_recovery_req <= 1'b1;
      @(posedge ref_clk);
      manual_recovery_req <= 1'b0;
      #1;
   endtask : pulse_manual

   function automatic logic [9:0] alm_exp(input gsa_pkg::gsa_alarm_s p);
      return {p.right_supply_fail, p.left_supply_fail,
         p.right_supply_overtemp, p.left_supply_overtemp, 1'b0, 1'b0,
         p.contact_closed};
   endfunction : alm_exp

   // Ctrl 3 is unused and reads as off, same as ctrl 0
   function automatic logic rly(input logic [3:0] t, input logic [1:0] k);
      if (k == 2'h1) return 1'b1;
      if (k != 2'h2) return 1'b0;
      if (t == 4'hb) return |a;
      if (t >= 4'h1 && t <= 4'ha) return a[t - 4'h1];
      return 1'b0;
   endfunction : rly

   // Quiet window and forwarded lines, both one cycle behind their cause
   always @(posedge ref_clk) begin
      #1;
      if (rec_d) chk(sync_out_r, 1'b0);
      if (reset_n === 1'b1) chk(pps_fwd, slave_d ? chn_d : gps_d);
      rec_d = src_r === gsa_pkg::SRC_RECOVERY;
      slave_d = is_slave_r;
      gps_d = gps_pps;
      chn_d = chain_gps_pps;
   end

   // Cut a hang short well past the expected run length
   initial begin
      repeat (90000) @(posedge ref_clk);
      err_total++;
      complete_run();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(cfg_r, gsa_pkg::CFG_RST);
      chk(relay_on, 3'h0);
      chk(is_slave_r, 1'b0);
      chk(src_r, gsa_pkg::SRC_INTERNAL);
      n = 0;
      count_sync(10 * SEC);
      chk(n, 10);
      for (int k = 0; k < 9; k++) begin
         @(posedge ref_clk);
         alarm_pins <= gsa_pkg::gsa_alarm_s'(8'h01 << k);
         for (int t = 0; t < 16; t++) begin
            s = 4'(t);
            c = gsa_pkg::CFG_RST;
            c.relay_sel = {s + 4'h2, s + 4'h1, s};
            load(c);
            a = alm_exp(alarm_pins);
            chk(alarm_in_state_r, a);
            chk(relay_on, {rly(s + 4'h2, 2'h2), rly(s + 4'h1, 2'h2),
               rly(s, 2'h2)});
         end
      end
      for (int v = 0; v < 2; v++) begin
         @(posedge ref_clk);
         alarm_pins <= gsa_pkg::gsa_alarm_s'(v ? 8'h80 : 8'h00);
         for (int k = 0; k < 4; k++) begin
            c = gsa_pkg::CFG_RST;
            c.relay_sel = {3{4'h4}};
            c.relay_ctrl = {2'(k + 2), 2'(k + 1), 2'(k)};
            load(c);
            a = alm_exp(alarm_pins);
            chk(relay_on, {rly(4'h4, 2'(k + 2)), rly(4'h4, 2'(k + 1)),
               rly(4'h4, 2'(k))});
         end
      end
      // adaptive dwell fixed; same dwell setting
      c = gsa_pkg::CFG_RST;
      c.dwell_ms = 16'h0064;
      c.adaptive_dwell = 1'b1;
      load(c);
      chk(dwell_ms_eff_r, gsa_pkg::ADAPT_DWELL_MS);
      c.adaptive_dwell = 1'b0;
      load(c);
      chk(dwell_ms_eff_r, 16'h0064);
      c.interval_min = 11'h003;
      load(c);
      chk(cfg_r.interval_min, gsa_pkg::INTERVAL_MIN);
      c.interval_min = 11'h7d0;
      load(c);
      chk(cfg_r.interval_min, gsa_pkg::INTERVAL_MAX);
      c.interval_min = gsa_pkg::INTERVAL_MIN;
      c.auto_en = 1'b0;
      load(c);
      chk(cfg_r, c);
      @(posedge ref_clk);
      gps_en <= 1'b1;
      repeat (3 * SEC) @(posedge ref_clk);
      #1;
      chk(src_r, gsa_pkg::SRC_INTERNAL);
      pulse_manual();
      chk(src_r, gsa_pkg::SRC_RECOVERY);
      wait_src(gsa_pkg::SRC_GPS, 6 * SEC);
      chk(src_r, gsa_pkg::SRC_GPS);
      chk(n > 4 * SEC - 10, 1'b1);
      chk(alarm_in_state_r[4], 1'b1);
      n = 0;
      count_sync(10 * SEC);
      chk(n, 10);
      // tolerance edge, then one cycle beyond
      @(posedge ref_clk);
      gps_per <= 8'h66;
      repeat (5 * SEC) @(posedge ref_clk);
      #1;
      chk(src_r, gsa_pkg::SRC_GPS);
      @(posedge ref_clk);
      gps_per <= 8'h67;
      wait_src(gsa_pkg::SRC_INTERNAL, 4 * SEC);
      chk(src_r, gsa_pkg::SRC_INTERNAL);
      chk(pps_proper_r, 1'b0);
      @(posedge ref_clk);
      gps_per <= 8'h64;
      chain_cable_present <= 1'b1;
      wait_src(gsa_pkg::SRC_CHAIN, 20);
      chk(is_slave_r, 1'b1);
      chk(src_r, gsa_pkg::SRC_CHAIN);
      @(posedge ref_clk);
      chain_sync <= 1'b1;
      @(posedge ref_clk);
      chain_sync <= 1'b0;
      #1;
      n = int'(sync_out_r === 1'b1);
      count_sync(4);
      chk(n, 1);
      pulse_manual();
      chk(src_r, gsa_pkg::SRC_CHAIN);
      @(posedge ref_clk);
      chn_en <= 1'b1;
      wait_src(gsa_pkg::SRC_GPS, 4 * SEC);
      chk(src_r, gsa_pkg::SRC_GPS);
      chk(n >= 2 * SEC, 1'b1);
      @(posedge ref_clk);
      chain_cable_present <= 1'b0;
      chn_en <= 1'b0;
      n = 0;
      repeat (310 * SEC) begin
         @(posedge ref_clk);
         #1;
         if (src_r === gsa_pkg::SRC_RECOVERY) n++;
      end
      chk(n, 0);
      c.auto_en = 1'b1;
      load(c);
      wait_src(gsa_pkg::SRC_RECOVERY, 310 * SEC);
      chk(src_r, gsa_pkg::SRC_RECOVERY);
      chk(n >= 298 * SEC, 1'b1);
      wait_src(gsa_pkg::SRC_GPS, 6 * SEC);
      chk(src_r, gsa_pkg::SRC_GPS);
      complete_run();
   end
endmodule : tb_gsa_top
